// file: hw/vpts_sequencer.sv
// teach-in sequencer: two buttons, three leds, stored closed/seat/open positions
// assumes position_in, target and switching inputs come from logic on clk_in;
// the two buttons are raw pins, active high when pressed
`timescale 1ns/1ps

// Contract
// - operator input comes only from the position-select and teach buttons.
// - two-position and three-position valves are both supported.
// - seal-wear monitoring only when two positions are taught.
// - programming starts at the closed-position step.
// - each position-select press skips to the next step; two reach open.
// - steps may be taught in any order, skipped ones later.
// - untaught seat position selects seal-wear mode at programming end.
// - run mode is entered after power-up without operator action.
// - no target at power-up blinks green until next power cycle.
// - target out of range blinks red.
// - all leds dark when no switching output is active.
// - selection cycles red, yellow, green; starts at closed (red).
// - single-seat valves skip the seat step, leaving it untaught.
// - hold position-select 2 s enters programming; all flash twice; closed lit.
// - teach at closed step stores closed, then seat led lights.
// - teach at open step stores open, then closed led relights.
// - holding position-select 5 s flashes open led at about 2 Hz.
// - release after long hold validates; if valid all flash twice.
// - failed validation flashes closed at 8 Hz until position-select acknowledge.
module vpts_sequencer
  import vpts_pkg::*;
#(
  parameter int POS_W = POS_W_DEF,
  parameter int MIN_SPAN = MIN_SPAN_DEF,
  parameter int ENTRY_HOLD = ENTRY_HOLD_CYC,
  parameter int EXIT_HOLD = EXIT_HOLD_CYC,
  parameter int DEBOUNCE = DEBOUNCE_CYC,
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int FLASH_PHASE = FLASH_PHASE_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // operator buttons (pins)
  input wire logic pos_btn_in,
  input wire logic teach_btn_in,
  // measurement and output state
  input wire logic [POS_W-1:0] position_in,
  input wire logic target_present_in,
  input wire logic in_range_in,
  input wire logic sw_closed_in,
  input wire logic sw_seat_in,
  input wire logic sw_open_in,
  // indicators: closed red, open green, seat yellow
  output logic led_closed_out,
  output logic led_seat_out,
  output logic led_open_out,
  // stored positions and mode
  output logic [POS_W-1:0] closed_pos_out,
  output logic [POS_W-1:0] seat_pos_out,
  output logic [POS_W-1:0] open_pos_out,
  output logic seal_wear_mode_out,
  output logic three_pos_mode_out,
  output logic prog_active_out
);
  localparam int FAST_HALF = int'((64'(SLOW_HALF) * SLOW_BLINK_MHZ) / FAST_BLINK_MHZ);

  if (POS_W < 2 || MIN_SPAN < 1 || ENTRY_HOLD < 1 || EXIT_HOLD <= ENTRY_HOLD || DEBOUNCE < 1 ||
      SLOW_HALF < 1 || FAST_HALF < 1 || FLASH_PHASE < 1) begin : g_bad_param
    $error("vpts_sequencer: unusable parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // button synchronisers and debounce
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] btn_db;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {teach_btn_in, pos_btn_in};
      sync2_r <= sync1_r;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_db
    logic [31:0] cnt_r;
    logic state_r;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        cnt_r <= 32'h0;
        state_r <= 1'b0;
      end else if (sync2_r[i] == state_r) begin
        cnt_r <= 32'h0;
      end else if (cnt_r >= 32'(DEBOUNCE - 1)) begin
        cnt_r <= 32'h0;
        state_r <= sync2_r[i];
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
    assign btn_db[i] = state_r;
  end

  logic [1:0] btn_q_r;
  logic pos_rise;
  logic pos_fall;
  logic teach_rise;
  logic [31:0] hold_cnt_r;
  logic hold_entry;
  logic hold_exit;

  assign pos_rise = btn_db[BTN_POS] & ~btn_q_r[BTN_POS];
  assign pos_fall = ~btn_db[BTN_POS] & btn_q_r[BTN_POS];
  assign teach_rise = btn_db[BTN_TEACH] & ~btn_q_r[BTN_TEACH];
  assign hold_entry = hold_cnt_r >= 32'(ENTRY_HOLD);
  assign hold_exit = hold_cnt_r >= 32'(EXIT_HOLD);

  // hold count saturates so a very long press cannot wrap into a short one
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      btn_q_r <= 2'h0;
      hold_cnt_r <= 32'h0;
    end else begin
      btn_q_r <= btn_db;
      if (!btn_db[BTN_POS]) begin
        hold_cnt_r <= 32'h0;
      end else if (!hold_exit) begin
        hold_cnt_r <= hold_cnt_r + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blink and flash timing
  logic [31:0] slow_cnt_r;
  logic [31:0] fast_cnt_r;
  logic slow_r;
  logic fast_r;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slow_cnt_r <= 32'h0;
      fast_cnt_r <= 32'h0;
      slow_r <= 1'b0;
      fast_r <= 1'b0;
    end else begin
      slow_cnt_r <= (slow_cnt_r >= 32'(SLOW_HALF - 1)) ? 32'h0 : slow_cnt_r + 32'h1;
      fast_cnt_r <= (fast_cnt_r >= 32'(FAST_HALF - 1)) ? 32'h0 : fast_cnt_r + 32'h1;
      if (slow_cnt_r >= 32'(SLOW_HALF - 1)) begin
        slow_r <= ~slow_r;
      end
      if (fast_cnt_r >= 32'(FAST_HALF - 1)) begin
        fast_r <= ~fast_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up target check, caught on the first edge after reset release
  logic boot_done_r;
  logic no_target_r;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_done_r <= 1'b0;
      no_target_r <= 1'b0;
    end else if (!boot_done_r) begin
      boot_done_r <= 1'b1;
      no_target_r <= ~target_present_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  vpts_state_t state_r;
  logic [1:0] step_r;
  logic armed_r;
  logic [31:0] phase_cnt_r;
  logic [2:0] phase_idx_r;
  logic [2:0] taught_r;
  logic [POS_W-1:0] closed_pos_r;
  logic [POS_W-1:0] seat_pos_r;
  logic [POS_W-1:0] open_pos_r;
  logic seal_wear_r;
  logic flash_done;
  logic [POS_W-1:0] span;
  logic valid;

  assign flash_done = (phase_idx_r == FLASH_PHASES - 3'h1) && (phase_cnt_r >= 32'(FLASH_PHASE - 1));
  assign span = (open_pos_r > closed_pos_r) ? open_pos_r - closed_pos_r : closed_pos_r - open_pos_r;
  // the seat point, when taught, must differ from both end points
  assign valid = taught_r[STEP_CLOSED] & taught_r[STEP_OPEN] & (span >= POS_W'(MIN_SPAN)) &
                 (~taught_r[STEP_SEAT] | ((seat_pos_r != closed_pos_r) & (seat_pos_r != open_pos_r)));

  // armed_r drops the release of the press that opened a session, so the
  // entry hold cannot also count as a skip
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_RUN;
      step_r <= STEP_CLOSED;
      armed_r <= 1'b0;
      taught_r <= 3'h0;
      seal_wear_r <= 1'b1;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (hold_entry) begin
            state_r <= ST_ENTRY;
            armed_r <= 1'b0;
          end
        end
        ST_ENTRY: begin
          if (flash_done) begin
            state_r <= ST_TEACH;
            step_r <= STEP_CLOSED;
          end
        end
        ST_TEACH: begin
          if (!btn_db[BTN_POS]) begin
            armed_r <= 1'b1;
          end
          if (pos_fall && armed_r && hold_exit) begin
            state_r <= valid ? ST_EXIT : ST_ERROR;
          end else if (pos_fall && armed_r) begin
            step_r <= (step_r == STEP_OPEN) ? STEP_CLOSED : step_r + 2'h1;
          end else if (teach_rise) begin
            taught_r[step_r] <= 1'b1;
            step_r <= (step_r == STEP_OPEN) ? STEP_CLOSED : step_r + 2'h1;
          end
        end
        ST_EXIT: begin
          if (flash_done) begin
            state_r <= ST_RUN;
            seal_wear_r <= ~taught_r[STEP_SEAT];
          end
        end
        ST_ERROR: begin
          if (pos_rise) begin
            state_r <= ST_TEACH;
            step_r <= STEP_CLOSED;
            taught_r <= 3'h0;
            armed_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      closed_pos_r <= '0;
      seat_pos_r <= '0;
      open_pos_r <= '0;
    end else if (state_r == ST_TEACH && teach_rise && !(pos_fall && armed_r)) begin
      case (step_r)
        STEP_CLOSED: closed_pos_r <= position_in;
        STEP_SEAT: seat_pos_r <= position_in;
        STEP_OPEN: open_pos_r <= position_in;
        default: closed_pos_r <= closed_pos_r;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_cnt_r <= 32'h0;
      phase_idx_r <= 3'h0;
    end else if (state_r != ST_ENTRY && state_r != ST_EXIT) begin
      phase_cnt_r <= 32'h0;
      phase_idx_r <= 3'h0;
    end else if (phase_cnt_r >= 32'(FLASH_PHASE - 1)) begin
      phase_cnt_r <= 32'h0;
      phase_idx_r <= phase_idx_r + 3'h1;
    end else begin
      phase_cnt_r <= phase_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators; led order {open, seat, closed}
  logic [2:0] led_nxt;
  logic [2:0] led_r;

  always_comb begin
    led_nxt = 3'h0;
    case (state_r)
      ST_ENTRY, ST_EXIT: led_nxt = phase_idx_r[0] ? 3'h0 : 3'h7;
      ST_TEACH: begin
        if (btn_db[BTN_POS] && hold_exit) begin
          led_nxt = {slow_r, 2'h0};
        end else begin
          led_nxt = 3'h1 << step_r;
        end
      end
      ST_ERROR: led_nxt = {2'h0, fast_r};
      ST_RUN: begin
        if (no_target_r) begin
          led_nxt = {slow_r, 2'h0};
        end else if (!in_range_in) begin
          led_nxt = {2'h0, slow_r};
        end else begin
          led_nxt = {sw_open_in, sw_seat_in, sw_closed_in};
        end
      end
      default: led_nxt = 3'h0;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      led_r <= 3'h0;
    end else begin
      led_r <= led_nxt;
    end
  end

  assign led_closed_out = led_r[STEP_CLOSED];
  assign led_seat_out = led_r[STEP_SEAT];
  assign led_open_out = led_r[STEP_OPEN];
  assign closed_pos_out = closed_pos_r;
  assign seat_pos_out = seat_pos_r;
  assign open_pos_out = open_pos_r;
  assign seal_wear_mode_out = seal_wear_r;
  assign three_pos_mode_out = ~seal_wear_r;
  assign prog_active_out = state_r != ST_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_entry_hold: assert property (state_r == ST_RUN && hold_entry |=> state_r == ST_ENTRY)
    else $error("long hold did not enter programming");
  a_entry_closed: assert property ($past(state_r) == ST_ENTRY && state_r == ST_TEACH
                                   |-> step_r == STEP_CLOSED && led_nxt == 3'h1)
    else $error("programming did not start at closed");
  a_skip_step: assert property (state_r == ST_TEACH && armed_r && pos_fall && !hold_exit && step_r == STEP_CLOSED
                                |=> step_r == STEP_SEAT ##0 state_r == ST_TEACH)
    else $error("skip did not advance");
  a_teach_closed: assert property (state_r == ST_TEACH && teach_rise && !pos_fall && step_r == STEP_CLOSED
                                   |=> closed_pos_r == $past(position_in) && step_r == STEP_SEAT ##1 led_r == 3'h2)
    else $error("closed teach wrong");
  a_teach_open: assert property (state_r == ST_TEACH && teach_rise && !pos_fall && step_r == STEP_OPEN
                                 |=> open_pos_r == $past(position_in) && step_r == STEP_CLOSED)
    else $error("open teach wrong");
  a_long_flash: assert property (state_r == ST_TEACH && btn_db[BTN_POS] && hold_exit
                                 |=> led_r == {$past(slow_r), 2'h0})
    else $error("exit hold indication wrong");
  a_validate: assert property (state_r == ST_TEACH && armed_r && pos_fall && hold_exit
                               |=> state_r == (valid ? ST_EXIT : ST_ERROR))
    else $error("validation outcome wrong");
  a_error_ack: assert property (state_r == ST_ERROR && !pos_rise |=> state_r == ST_ERROR ##0 led_r[2:1] == 2'h0)
    else $error("error left without acknowledge");
  a_seal_mode: assert property ($past(state_r) == ST_EXIT && state_r == ST_RUN
                                |-> seal_wear_mode_out == ~taught_r[STEP_SEAT])
    else $error("seal wear mode not chosen from seat");
  a_dark_leds: assert property (state_r == ST_RUN && !no_target_r && in_range_in &&
                                !(sw_closed_in | sw_seat_in | sw_open_in) |=> led_r == 3'h0)
    else $error("leds lit with no output active");
  a_no_target: assert property (state_r == ST_RUN && no_target_r |=> led_r == {$past(slow_r), 2'h0})
    else $error("no target blink wrong");
  c_enter_prog: cover property (state_r == ST_ENTRY ##1 state_r == ST_TEACH);
  c_good_exit: cover property (state_r == ST_EXIT ##1 state_r == ST_RUN);
  c_error_ack: cover property (state_r == ST_ERROR ##1 state_r == ST_TEACH);
endmodule // vpts_sequencer

// file: hw/vpts_pkg.sv
// constants and types for the valve position teach sequencer
// assumes a single 200 MHz clock; all times below are converted to cycles here
package vpts_pkg;

  localparam longint unsigned CLK_HZ = 64'd200_000_000;

  // times in their printed units
  localparam longint unsigned ENTRY_HOLD_MS = 64'd2000;
  localparam longint unsigned EXIT_HOLD_MS = 64'd5000;
  localparam longint unsigned DEBOUNCE_MS = 64'd10;
  localparam longint unsigned SLOW_BLINK_MHZ = 64'd2000;
  localparam longint unsigned FAST_BLINK_MHZ = 64'd8000;
  localparam longint unsigned FLASH_PHASE_MS = 64'd250;

  // least times round up, blink half periods are nominal
  localparam int ENTRY_HOLD_CYC = int'((CLK_HZ * ENTRY_HOLD_MS + 64'd999) / 64'd1000);
  localparam int EXIT_HOLD_CYC = int'((CLK_HZ * EXIT_HOLD_MS + 64'd999) / 64'd1000);
  localparam int DEBOUNCE_CYC = int'((CLK_HZ * DEBOUNCE_MS + 64'd999) / 64'd1000);
  localparam int SLOW_HALF_CYC = int'((CLK_HZ * 64'd1000) / (SLOW_BLINK_MHZ * 64'd2));
  localparam int FAST_HALF_CYC = int'((CLK_HZ * 64'd1000) / (FAST_BLINK_MHZ * 64'd2));
  localparam int FLASH_PHASE_CYC = int'((CLK_HZ * FLASH_PHASE_MS) / 64'd1000);

  // two flashes: on, off, on, off
  localparam logic [2:0] FLASH_PHASES = 3'h4;

  localparam int POS_W_DEF = 10;
  localparam int MIN_SPAN_DEF = 10;

  // teach steps, also the led index
  localparam logic [1:0] STEP_CLOSED = 2'h0;
  localparam logic [1:0] STEP_SEAT = 2'h1;
  localparam logic [1:0] STEP_OPEN = 2'h2;

  // button indices
  localparam int BTN_POS = 0;
  localparam int BTN_TEACH = 1;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_ENTRY,
    ST_TEACH,
    ST_EXIT,
    ST_ERROR
  } vpts_state_t;

endpackage

// file: bench/vpts_operator.sv
// operator model: a person pressing the two push buttons
// assumes the bench calls press() just after a falling clock edge
`timescale 1ns/1ps
module vpts_operator (
  // clock
  input wire logic clk_in,
  // button pins, high while pressed
  output logic pos_btn_out,
  output logic teach_btn_out
);
  initial begin
    pos_btn_out = 1'b0;
    teach_btn_out = 1'b0;
  end

  task automatic set_btn(input bit teach, input logic v);
    if (teach) begin
      teach_btn_out = v;
    end else begin
      pos_btn_out = v;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // contacts bounce on make: a one-cycle touch comes before the firm press
  task automatic press(input bit teach, input int hold);
    set_btn(teach, 1'b1);
    @(negedge clk_in);
    set_btn(teach, 1'b0);
    @(negedge clk_in);
    set_btn(teach, 1'b1);
    repeat (hold) @(negedge clk_in);
    set_btn(teach, 1'b0);
    // let the release pass the debounce before anything else is done
    repeat (8) @(negedge clk_in);
  endtask
endmodule // vpts_operator

// file: bench/tb_top.sv
// bench for the teach sequencer: operator model plus an integer step model
// assumes shortened hold, debounce and blink counts set at the instance
`timescale 1ns/1ps
module tb_top;
  import vpts_pkg::*;
  localparam int PW = POS_W_DEF;
  logic clk_in, reset_n_in, pos_btn, teach_btn;
  logic [PW-1:0] position_in;
  logic target_present_in, in_range_in, sw_closed_in, sw_seat_in, sw_open_in;
  logic led_closed_out, led_seat_out, led_open_out;
  logic [PW-1:0] closed_pos_out, seat_pos_out, open_pos_out;
  logic seal_wear_mode_out, three_pos_mode_out, prog_active_out;
  logic [2:0] leds;
  int n_errors, tests_run, seed, step, p;
  int stored[3];
  bit taught[3];
  assign leds = {led_open_out, led_seat_out, led_closed_out};

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  vpts_sequencer #(.ENTRY_HOLD(40), .EXIT_HOLD(100), .DEBOUNCE(2), .SLOW_HALF(5),
    .FLASH_PHASE(4)) vpts_sequencer_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .pos_btn_in(pos_btn), .teach_btn_in(teach_btn), .position_in(position_in),
    .target_present_in(target_present_in), .in_range_in(in_range_in), .sw_closed_in(sw_closed_in),
    .sw_seat_in(sw_seat_in), .sw_open_in(sw_open_in), .led_closed_out(led_closed_out),
    .led_seat_out(led_seat_out), .led_open_out(led_open_out), .closed_pos_out(closed_pos_out),
    .seat_pos_out(seat_pos_out), .open_pos_out(open_pos_out), .seal_wear_mode_out(seal_wear_mode_out),
    .three_pos_mode_out(three_pos_mode_out), .prog_active_out(prog_active_out));

  vpts_operator vpts_operator_inst (.clk_in(clk_in), .pos_btn_out(pos_btn), .teach_btn_out(teach_btn));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_bits(input string what, input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_pos(input string what, input logic [PW-1:0] exp, input logic [PW-1:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a wait that runs out is a mismatch and ends the run
  task automatic wait_leds(input logic [2:0] exp, input int bound);
    int i;
    for (i = 0; i < bound && leds !== exp; i++) @(negedge clk_in);
    check_bits("leds", exp, leds);
    if (leds !== exp) print_verdict();
  endtask

  // only the masked led may toggle, and it must be seen both lit and dark
  task automatic see_blink(input logic [2:0] mask, input int n);
    logic [2:0] any1, all1;
    any1 = 3'h0;
    all1 = 3'h7;
    repeat (n) begin
      @(negedge clk_in);
      any1 = any1 | leds;
      all1 = all1 & leds;
    end
    check_bits("blink_seen", mask, any1);
    check_bits("blink_low", 3'h0, all1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // step model: closed, seat, open, then round again
  task automatic enter_prog();
    fork
      vpts_operator_inst.press(1'b0, 60);
      wait_leds(3'h7, 80);
    join
    wait_leds(3'h1, 40);
    step = 0;
  endtask

  task automatic skip_step();
    step = (step + 1) % 3;
    vpts_operator_inst.press(1'b0, 6);
    wait_leds(3'(1 << step), 20);
  endtask

  task automatic teach_at(input int v);
    int s;
    s = step;
    position_in = PW'(v);
    stored[s] = v;
    taught[s] = 1'b1;
    step = (step + 1) % 3;
    vpts_operator_inst.press(1'b1, 4);
    wait_leds(3'(1 << step), 20);
    check_pos("stored", PW'(v), s == 0 ? closed_pos_out : s == 1 ? seat_pos_out : open_pos_out);
  endtask

  task automatic leave_prog();
    int d;
    bit ok;
    fork
      vpts_operator_inst.press(1'b0, 150);
      begin
        repeat (120) @(negedge clk_in);
        see_blink(3'h4, 24);
      end
    join
    d = stored[2] - stored[0];
    if (d < 0) d = -d;
    ok = taught[0] && taught[2] && d >= MIN_SPAN_DEF;
    ok = ok && (!taught[1] || (stored[1] != stored[0] && stored[1] != stored[2]));
    if (ok) begin
      wait_leds(3'h7, 60);
      repeat (30) @(negedge clk_in);
      check_bits("prog", 3'h0, {2'h0, prog_active_out});
      check_bits("seal", {2'h0, !taught[1]}, {2'h0, seal_wear_mode_out});
      check_bits("three", {2'h0, taught[1]}, {2'h0, three_pos_mode_out});
    end else begin
      see_blink(3'h1, 30);
      check_bits("prog", 3'h1, {2'h0, prog_active_out});
      vpts_operator_inst.press(1'b0, 6);
      wait_leds(3'h1, 30);
      step = 0;
      taught = '{0, 0, 0};
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2ae768da;
    n_errors = 0;
    tests_run = 0;
    position_in = '0;
    target_present_in = 1'b1;
    in_range_in = 1'b1;
    {sw_open_in, sw_seat_in, sw_closed_in} = 3'h0;
    reset_n_in = 1'b0;
    repeat (10) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check_bits("prog", 3'h0, {2'h0, prog_active_out});
    check_bits("leds_dark", 3'h0, leds);
    repeat (8) begin
      {sw_open_in, sw_seat_in, sw_closed_in} = 3'($random(seed));
      repeat (2) @(negedge clk_in);
      check_bits("run_leds", {sw_open_in, sw_seat_in, sw_closed_in}, leds);
    end
    in_range_in = 1'b0;
    see_blink(3'h1, 30);
    in_range_in = 1'b1;
    $display("test run_mode done");
    // two positions, seat skipped
    p = $random(seed) & 32'h1FF;
    enter_prog();
    teach_at(p);
    skip_step();
    teach_at(p + 20 + ($random(seed) & 32'hFF));
    leave_prog();
    $display("test two_pos done");
    // start at open, then fill the skipped steps
    p = $random(seed) & 32'hFF;
    enter_prog();
    skip_step();
    skip_step();
    teach_at(p + 300);
    teach_at(p);
    teach_at(p + 150);
    leave_prog();
    $display("test three_pos done");
    // span too small is refused and must be acknowledged
    enter_prog();
    teach_at(p);
    skip_step();
    teach_at(p + 3);
    leave_prog();
    $display("test error_ack done");
    // reset in mid-session with no target seen
    target_present_in = 1'b0;
    reset_n_in = 1'b0;
    repeat (10) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    target_present_in = 1'b1;
    see_blink(3'h4, 30);
    check_bits("prog", 3'h0, {2'h0, prog_active_out});
    $display("test no_target done");
    print_verdict();
  end
endmodule // tb_top
